// ---- spb_defs.svh ----
// constants for the serial port block: offsets, fields, reset values, timing
`ifndef SPB_DEFS_SVH
`define SPB_DEFS_SVH
`define SPB_OFF_CTRL 12'h000
`define SPB_OFF_BUF 12'h004
`define SPB_OFF_T2CTRL 12'h008
`define SPB_OFF_T2CNT 12'h00C
`define SPB_OFF_RELOAD 12'h010
`define SPB_OFF_T1TICK 12'h014
`define SPB_CTRL_RST 32'h0000_0000
`define SPB_T2CTRL_RST 32'h0000_0000
// serial control fields
`define SPB_F_RXF 0
`define SPB_F_TXF 1
`define SPB_F_R9 2
`define SPB_F_REN 4
`define SPB_F_MPE 5
`define SPB_F_MODE 6
// timer 2 control fields
`define SPB_F_RCS 0
`define SPB_F_CNT 1
`define SPB_F_RUN 2
`define SPB_F_EXE 3
`define SPB_F_TCS 4
`define SPB_F_RCLK 5
`define SPB_F_EXF 6
// one state time is two oscillator periods, one machine cycle twelve
`define SPB_STATE_DIV 2
`define SPB_PHASES 12
`define SPB_OVS 16
`endif

// ---- spb_pkg.sv ----
// types shared by the serial port block
package spb_pkg;
    typedef struct packed {
        logic rxd_o;
        logic rxd_oe;
        logic txd_o;
    } spb_pins_type;
    typedef enum logic [1:0] {
        SPB_TX_IDLE = 2'b00,
        SPB_TX_WAIT = 2'b01,
        SPB_TX_SEND = 2'b10
    } spb_tx_state_type;
    typedef enum logic [1:0] {
        SPB_RX_IDLE = 2'b00,
        SPB_RX_ARM = 2'b01,
        SPB_RX_BUSY = 2'b10
    } spb_rx_state_type;
endpackage

// ---- spb_timer2.sv ----
// timer 2 as baud rate generator with 16-bit auto reload
`timescale 1ns/10ps
`include "spb_defs.svh"
module spb_timer2 (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic count_ext,
    input wire logic ext_enable,
    input wire logic state_tick,
    input wire logic ext_fall,
    input wire logic t2_pin_fall,
    // counter access
    input wire logic [15:0] reload,
    input wire logic cnt_we,
    input wire logic [15:0] cnt_wdata,
    // results
    output logic [15:0] count,
    output logic overflow,
    output logic ext_flag_set
);
    logic [15:0] cnt_ff, nxt_cnt;
    logic inc;
    // timer function counts state times, counter function counts pin falls
    always_comb begin
        inc = run && (count_ext ? t2_pin_fall : state_tick);
        nxt_cnt = cnt_ff;
        if (cnt_we) begin
            nxt_cnt = cnt_wdata;
        end else if (inc) begin
            nxt_cnt = (cnt_ff == 16'hFFFF) ? reload : cnt_ff + 16'h0001;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    assign count = cnt_ff;
    assign overflow = inc && !cnt_we && (cnt_ff == 16'hFFFF);
    assign ext_flag_set = ext_enable && ext_fall;

    chk_reload_value: assert property (@(posedge clock) disable iff (rst)
        overflow |=> cnt_ff == $past(reload)) else $error("reload not taken");
    chk_state_rate: assert property (@(posedge clock) disable iff (rst)
        (run && !count_ext && !state_tick && !cnt_we) |=> $stable(cnt_ff))
        else $error("timer moved off tick");
endmodule

// ---- spb_serial.sv ----
// serial port modes 0 and 1 with timer 2 baud generator, APB slave
//
// Function
// - Timer 2 clocks a direction whenever its transmit or receive select is set.
// - High byte rollover reloads both timer bytes from the reload registers.
// - Asynchronous bit rate equals timer 2 overflow rate over sixteen.
// - As baud generator timer 2 counts each state time, oscillator over two.
// - Resulting bit rate is oscillator over 32 times (65536 minus reload).
// - Baud generator rollover never sets the timer 2 overflow flag.
// - With external enable, a falling timer 2 external pin sets the external flag.
// - Mode 0 shifts 8 bits LSB first on rx pin, clock on tx pin.
// - Mode 0 buffer write loads marker; sending begins one machine cycle later.
// - Shift clock low S3 to S5, high S6 to S2; right shift at S6P2.
// - Mode 0 transmit ends with final shift and transmit flag at tenth cycle.
// - Mode 0 receive starts on enable with flag clear; shifter loads 11111110.
// - Mode 0 receive shifts left at S6P2 taking pin sampled at S5P2.
// - Mode 0 receive loads buffer and sets flag when initial zero reaches left.
// - Mode 1 frame: start 0, eight data LSB first, stop 1.
// - Mode 1 write loads marker; start bit at next rollover, data later.
// - Mode 1 transmit sets flag and stops at tenth rollover after write.
// - Mode 1 receiver on falling edge resets divider and loads 1FF.
// - Majority of samples 7, 8, 9; bad start bit resumes hunting.
// - Frame accepted only with flag clear and multiproc off or stop bit one.
// - After the stop bit sample the receiver hunts for a new edge.
// - Reception happens only while receive enable stays set.
`timescale 1ns/10ps
`include "spb_defs.svh"
module spb_serial (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic rxd_i,
    input wire logic timer2_ext_pin_i,
    input wire logic t2_pin_i,
    output spb_pkg::spb_pins_type pins,
    // timer 1 overflow from outside the block
    input wire logic t1_overflow
);
    import spb_pkg::*;

    // synchronisers for pins
    logic [1:0] rxd_sync_ff, ex_sync_ff, t2p_sync_ff;
    logic ex_last_ff, t2p_last_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            rxd_sync_ff <= 2'b11;
            ex_sync_ff <= 2'b11;
            t2p_sync_ff <= 2'b11;
            ex_last_ff <= 1'b1;
            t2p_last_ff <= 1'b1;
        end else begin
            rxd_sync_ff <= {rxd_sync_ff[0], rxd_i};
            ex_sync_ff <= {ex_sync_ff[0], timer2_ext_pin_i};
            t2p_sync_ff <= {t2p_sync_ff[0], t2_pin_i};
            ex_last_ff <= ex_sync_ff[1];
            t2p_last_ff <= t2p_sync_ff[1];
        end
    end
    logic rxd, ex_fall, t2p_fall;
    assign rxd = rxd_sync_ff[1];
    assign ex_fall = ex_last_ff && !ex_sync_ff[1];
    assign t2p_fall = t2p_last_ff && !t2p_sync_ff[1];

    // phase counter: 12 oscillator periods per machine cycle, S1P1..S6P2
    logic [3:0] ph_ff, nxt_ph;
    always_comb begin
        nxt_ph = (ph_ff == 4'(`SPB_PHASES - 1)) ? 4'h0 : ph_ff + 4'h1;
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            ph_ff <= 4'h0;
        end else begin
            ph_ff <= nxt_ph;
        end
    end
    function automatic logic at_phase(input logic [3:0] ph, input int s, input int p);
        at_phase = (ph == 4'((s - 1) * 2 + (p - 1)));
    endfunction
    logic s6p2, s5p2, s1p1, s3p1, s6p1, state_tick;
    assign s6p2 = at_phase(ph_ff, 6, 2);
    assign s5p2 = at_phase(ph_ff, 5, 2);
    assign s1p1 = at_phase(ph_ff, 1, 1);
    assign s3p1 = at_phase(ph_ff, 3, 1);
    assign s6p1 = at_phase(ph_ff, 6, 1);
    assign state_tick = ph_ff[0];

    // shifters fill from the right, so the first bit on the line lands leftmost
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7 - i];
        end
    endfunction

    // registers
    logic [7:0] ctrl_ff, nxt_ctrl, t2c_ff, nxt_t2c, buf_ff, nxt_buf;
    logic [15:0] reload_ff, nxt_reload, t2_count;
    logic wr_en, rd_en, hit;
    logic t2_ovf, t2_ext_set, cnt_we;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign hit = (paddr == `SPB_OFF_CTRL) || (paddr == `SPB_OFF_BUF) || (paddr == `SPB_OFF_T2CTRL)
        || (paddr == `SPB_OFF_T2CNT) || (paddr == `SPB_OFF_RELOAD);
    assign pslverr = psel && penable && !hit;
    assign cnt_we = wr_en && paddr == `SPB_OFF_T2CNT;

    spb_timer2 u_t2 (
        .clock(clock),
        .rst(rst),
        .run(t2c_ff[`SPB_F_RUN]),
        .count_ext(t2c_ff[`SPB_F_CNT]),
        .ext_enable(t2c_ff[`SPB_F_EXE]),
        .state_tick(state_tick),
        .ext_fall(ex_fall),
        .t2_pin_fall(t2p_fall),
        .reload(reload_ff),
        .cnt_we(cnt_we),
        .cnt_wdata(pwdata[15:0]),
        .count(t2_count),
        .overflow(t2_ovf),
        .ext_flag_set(t2_ext_set)
    );

    // per direction baud tick and divide by 16
    logic tx_src, rx_src;
    assign tx_src = t2c_ff[`SPB_F_TCS] ? t2_ovf : t1_overflow;
    assign rx_src = t2c_ff[`SPB_F_RCS] ? t2_ovf : t1_overflow;
    logic [3:0] txdiv_ff, nxt_txdiv, rxdiv_ff, nxt_rxdiv;
    logic tx_roll, mode1;
    assign mode1 = ctrl_ff[`SPB_F_MODE];
    assign tx_roll = tx_src && txdiv_ff == 4'hF;

    // transmit
    spb_tx_state_type tx_st_ff, nxt_tx_st;
    logic [8:0] tsh_ff, nxt_tsh;
    logic [3:0] tcnt_ff, nxt_tcnt;
    logic txo_ff, nxt_txo, sclk_ff, nxt_sclk, t_set;
    logic buf_wr;
    assign buf_wr = wr_en && paddr == `SPB_OFF_BUF;
    always_comb begin
        nxt_tx_st = tx_st_ff;
        nxt_tsh = tsh_ff;
        nxt_tcnt = tcnt_ff;
        nxt_txo = txo_ff;
        t_set = 1'b0;
        if (buf_wr) begin
            nxt_tsh = {1'b1, pwdata[7:0]};
            nxt_tx_st = SPB_TX_WAIT;
            nxt_tcnt = 4'h0;
        end else begin
            case (tx_st_ff)
                SPB_TX_IDLE: begin
                    nxt_txo = 1'b1;
                end
                SPB_TX_WAIT: begin
                    if (!mode1 && s6p2) begin
                        // bus writes land at any phase; wait a full machine cycle
                        nxt_tcnt = 4'h1;
                        if (tcnt_ff == 4'h1) begin
                            nxt_tx_st = SPB_TX_SEND;
                            nxt_tcnt = 4'h0;
                        end
                    end else if (mode1 && tx_roll) begin
                        nxt_tx_st = SPB_TX_SEND;
                        nxt_txo = 1'b0;
                        nxt_tcnt = 4'h1;
                    end
                end
                SPB_TX_SEND: begin
                    if (!mode1) begin
                        nxt_txo = tsh_ff[0];
                        if (s6p2) begin
                            nxt_tsh = {1'b0, tsh_ff[8:1]};
                            nxt_tcnt = tcnt_ff + 4'h1;
                        end
                        if (s1p1 && tcnt_ff == 4'h8) begin
                            nxt_tx_st = SPB_TX_IDLE;
                            t_set = 1'b1;
                            nxt_txo = 1'b1;
                        end
                    end else if (tx_roll) begin
                        nxt_tcnt = tcnt_ff + 4'h1;
                        if (tcnt_ff == 4'h9) begin
                            nxt_tx_st = SPB_TX_IDLE;
                            t_set = 1'b1;
                            nxt_txo = 1'b1;
                        end else if (tcnt_ff == 4'h1) begin
                            nxt_txo = tsh_ff[0];
                        end else begin
                            nxt_tsh = {1'b0, tsh_ff[8:1]};
                            nxt_txo = tsh_ff[1];
                        end
                    end
                end
                default: nxt_tx_st = SPB_TX_IDLE;
            endcase
        end
        nxt_txdiv = tx_src ? txdiv_ff + 4'h1 : txdiv_ff;
    end

    // receive
    spb_rx_state_type rx_st_ff, nxt_rx_st;
    logic [8:0] rsh_ff, nxt_rsh;
    logic [2:0] smp_ff, nxt_smp;
    logic [3:0] rcnt_ff, nxt_rcnt;
    logic r_set, r9_set, r9_val, rx_last_ff, samp_ff, nxt_samp, maj;
    assign maj = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2]) | (smp_ff[1] & smp_ff[2]);
    always_comb begin
        nxt_rx_st = rx_st_ff;
        nxt_rsh = rsh_ff;
        nxt_smp = smp_ff;
        nxt_rcnt = rcnt_ff;
        nxt_rxdiv = rx_src ? rxdiv_ff + 4'h1 : rxdiv_ff;
        nxt_samp = samp_ff;
        nxt_buf = buf_ff;
        r_set = 1'b0;
        r9_set = 1'b0;
        r9_val = 1'b0;
        if (!ctrl_ff[`SPB_F_REN]) begin
            nxt_rx_st = SPB_RX_IDLE;
        end else begin
            case (rx_st_ff)
                SPB_RX_IDLE: begin
                    if (!mode1 && !ctrl_ff[`SPB_F_RXF] && s6p2) begin
                        nxt_rsh = 9'h0FE;
                        nxt_rx_st = SPB_RX_BUSY;
                        nxt_rcnt = 4'h0;
                    end else if (mode1 && rx_src && rx_last_ff && !rxd) begin
                        nxt_rxdiv = 4'h0;
                        nxt_rsh = 9'h1FF;
                        nxt_rx_st = SPB_RX_ARM;
                    end
                end
                SPB_RX_ARM, SPB_RX_BUSY: begin
                    if (!mode1) begin
                        if (s5p2) begin
                            nxt_samp = rxd;
                        end
                        if (s6p2) begin
                            nxt_rsh = {rsh_ff[7:0], samp_ff};
                            nxt_rcnt = rcnt_ff + 4'h1;
                            if (!rsh_ff[7]) begin
                                nxt_buf = rev8({rsh_ff[6:0], samp_ff});
                            end
                        end
                        if (s1p1 && rcnt_ff == 4'h8) begin
                            nxt_rx_st = SPB_RX_IDLE;
                            r_set = 1'b1;
                        end
                    end else if (rx_src) begin
                        if (rxdiv_ff >= 4'h6 && rxdiv_ff <= 4'h8) begin
                            nxt_smp = {smp_ff[1:0], rxd};
                        end
                        if (rxdiv_ff == 4'h9) begin
                            if (rx_st_ff == SPB_RX_ARM) begin
                                nxt_rx_st = maj ? SPB_RX_IDLE : SPB_RX_BUSY;
                                nxt_rsh = {rsh_ff[7:0], maj};
                            end else if (!rsh_ff[8]) begin
                                nxt_rx_st = SPB_RX_IDLE;
                                if (!ctrl_ff[`SPB_F_RXF] && (!ctrl_ff[`SPB_F_MPE] || maj)) begin
                                    nxt_buf = rev8(rsh_ff[7:0]);
                                    r_set = 1'b1;
                                    r9_set = 1'b1;
                                    r9_val = maj;
                                end
                            end else begin
                                nxt_rsh = {rsh_ff[7:0], maj};
                            end
                        end
                    end
                end
                default: nxt_rx_st = SPB_RX_IDLE;
            endcase
        end
        if (buf_wr) begin
            nxt_buf = buf_ff;
        end
    end

    // shift clock in mode 0 while sending or receiving
    always_comb begin
        nxt_sclk = 1'b1;
        if (!mode1 && (tx_st_ff == SPB_TX_SEND || rx_st_ff == SPB_RX_BUSY)) begin
            nxt_sclk = (nxt_ph >= 4'h4 && nxt_ph <= 4'h9) ? 1'b0 : 1'b1;
        end
    end

    // register writes; hardware set wins over software clear
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_t2c = t2c_ff;
        nxt_reload = reload_ff;
        if (wr_en && paddr == `SPB_OFF_CTRL) begin
            nxt_ctrl = pwdata[7:0];
        end
        if (wr_en && paddr == `SPB_OFF_T2CTRL) begin
            nxt_t2c = pwdata[7:0];
        end
        if (wr_en && paddr == `SPB_OFF_RELOAD) begin
            nxt_reload = pwdata[15:0];
        end
        if (t_set) begin
            nxt_ctrl[`SPB_F_TXF] = 1'b1;
        end
        if (r_set) begin
            nxt_ctrl[`SPB_F_RXF] = 1'b1;
        end
        if (r9_set) begin
            nxt_ctrl[`SPB_F_R9] = r9_val;
        end
        if (t2_ext_set) begin
            nxt_t2c[`SPB_F_EXF] = 1'b1;
        end
        // baud generator rollover leaves the overflow flag alone
        nxt_t2c[`SPB_F_RCLK] = nxt_t2c[`SPB_F_RCLK] | (t2_ovf && !(t2c_ff[`SPB_F_TCS] | t2c_ff[`SPB_F_RCS]));
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff <= 8'(`SPB_CTRL_RST);
            t2c_ff <= 8'(`SPB_T2CTRL_RST);
            reload_ff <= 16'h0000;
            buf_ff <= 8'h00;
            tx_st_ff <= SPB_TX_IDLE;
            tsh_ff <= 9'h000;
            tcnt_ff <= 4'h0;
            txo_ff <= 1'b1;
            sclk_ff <= 1'b1;
            txdiv_ff <= 4'h0;
            rxdiv_ff <= 4'h0;
            rx_st_ff <= SPB_RX_IDLE;
            rsh_ff <= 9'h000;
            smp_ff <= 3'h7;
            rcnt_ff <= 4'h0;
            samp_ff <= 1'b1;
            rx_last_ff <= 1'b1;
        end else begin
            ctrl_ff <= nxt_ctrl;
            t2c_ff <= nxt_t2c;
            reload_ff <= nxt_reload;
            buf_ff <= nxt_buf;
            tx_st_ff <= nxt_tx_st;
            tsh_ff <= nxt_tsh;
            tcnt_ff <= nxt_tcnt;
            txo_ff <= nxt_txo;
            sclk_ff <= nxt_sclk;
            txdiv_ff <= nxt_txdiv;
            rxdiv_ff <= nxt_rxdiv;
            rx_st_ff <= nxt_rx_st;
            rsh_ff <= nxt_rsh;
            smp_ff <= nxt_smp;
            rcnt_ff <= nxt_rcnt;
            samp_ff <= nxt_samp;
            rx_last_ff <= rx_src ? rxd : rx_last_ff;
        end
    end

    // pins: mode 0 drives data on rx pin and clock on tx pin
    assign pins.rxd_o = txo_ff;
    assign pins.rxd_oe = !mode1 && tx_st_ff == SPB_TX_SEND;
    assign pins.txd_o = mode1 ? txo_ff : sclk_ff;

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `SPB_OFF_CTRL: prdata = {24'h000000, ctrl_ff};
                `SPB_OFF_BUF: prdata = {24'h000000, buf_ff};
                `SPB_OFF_T2CTRL: prdata = {24'h000000, t2c_ff};
                `SPB_OFF_T2CNT: prdata = {16'h0000, t2_count};
                `SPB_OFF_RELOAD: prdata = {16'h0000, reload_ff};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    chk_tx_flag_end: assert property (@(posedge clock) disable iff (rst)
        (!mode1 && tx_st_ff == SPB_TX_SEND && tcnt_ff == 4'h8) |-> tsh_ff == 9'h001)
        else $error("marker not alone at end of mode 0 send");
    chk_tx_done_flag: assert property (@(posedge clock) disable iff (rst)
        (t_set && !buf_wr) |=> ctrl_ff[`SPB_F_TXF] && tx_st_ff == SPB_TX_IDLE)
        else $error("tx flag not set at end");
    chk_rx_enable: assert property (@(posedge clock) disable iff (rst)
        !ctrl_ff[`SPB_F_REN] |=> rx_st_ff == SPB_RX_IDLE) else $error("rx without enable");
    chk_rx_accept: assert property (@(posedge clock) disable iff (rst)
        r9_set |=> ctrl_ff[`SPB_F_RXF] && ctrl_ff[`SPB_F_R9] == $past(maj))
        else $error("accepted frame not flagged");
    chk_m1_start: assert property (@(posedge clock) disable iff (rst)
        (mode1 && tx_st_ff == SPB_TX_WAIT && tx_roll && !buf_wr) |=> !txo_ff)
        else $error("no start bit");
    chk_m0_load: assert property (@(posedge clock) disable iff (rst)
        (!mode1 && rx_st_ff == SPB_RX_IDLE && nxt_rx_st == SPB_RX_BUSY) |=> rsh_ff == 9'h0FE)
        else $error("bad mode 0 rx load");
    chk_m1_hunt: assert property (@(posedge clock) disable iff (rst)
        (mode1 && rx_st_ff == SPB_RX_IDLE && nxt_rx_st == SPB_RX_ARM) |=> rxdiv_ff == 4'h0 && rsh_ff == 9'h1FF)
        else $error("bad edge restart");
    chk_no_t2_flag: assert property (@(posedge clock) disable iff (rst)
        (t2_ovf && (t2c_ff[`SPB_F_TCS] | t2c_ff[`SPB_F_RCS]) && !wr_en) |=> $stable(t2c_ff[`SPB_F_RCLK]))
        else $error("overflow flag set in baud mode");
endmodule

// ---- spb_far_end.sv ----
// far-end model: mode 0 shift register and mode 1 serial partner
`timescale 1ns/10ps
module spb_far_end (
    // clock
    input wire logic clock,
    // lines from the serial port
    input wire logic txd,
    input wire logic data_in,
    input wire logic data_oe,
    // line back to the serial port
    output logic rxd
);
    logic mode1 = 1'b0;
    logic frame_ok = 1'b0;
    logic [7:0] sh_in = 8'h00;
    logic [7:0] out_byte = 8'h00;
    int bit_clks = 64;
    int n_out = 0;
    initial rxd = 1'b1;
    // mode 0: take data on the rising shift clock, present the next bit after it
    always @(posedge txd) begin
        if (!mode1 && data_oe) begin
            sh_in = {data_in, sh_in[7:1]};
        end else if (!mode1 && n_out > 0) begin
            n_out = n_out - 1;
            out_byte = out_byte >> 1;
            // line released after the last bit, pull-up wins
            rxd <= (n_out == 0) ? 1'b1 : out_byte[0];
        end
    end
    // mode 1: sample each bit in its middle
    always @(negedge txd) begin
        if (mode1) begin
            repeat (bit_clks / 2) @(posedge clock);
            frame_ok = (txd == 1'b0);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_clks) @(posedge clock);
                sh_in = {txd, sh_in[7:1]};
            end
            repeat (bit_clks) @(posedge clock);
            frame_ok = frame_ok && txd;
        end
    end
    task automatic load0(input logic [7:0] b);
        out_byte = b;
        n_out = 8;
        rxd <= b[0];
    endtask
    task automatic send(input logic [7:0] b, input logic stop);
        rxd <= 1'b0;
        repeat (bit_clks) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (bit_clks) @(posedge clock);
        end
        rxd <= stop;
        repeat (bit_clks) @(posedge clock);
        rxd <= 1'b1;
    endtask
    // false start shorter than the middle samples
    task automatic glitch;
        rxd <= 1'b0;
        repeat (3) @(posedge clock);
        rxd <= 1'b1;
    endtask
endmodule

// ---- serial_port_modes_0_1_baudgen_tb.sv ----
// self-checking bench for the serial port block
`timescale 1ns/10ps
`include "spb_defs.svh"
module serial_port_modes_0_1_baudgen_tb;
    import spb_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic timer2_ext_pin = 1'b1;
    logic t1_ovf = 1'b0;
    logic [1:0] t1_div = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic far_rxd;
    logic rxd_line;
    spb_pins_type pins;
    int n_fail = 0;
    int tests_run = 0;
    int k;
    always #4 clock = ~clock;
    // timer 1 stand-in pulses every fourth clock
    always @(posedge clock) begin
        t1_div <= t1_div + 2'h1;
        t1_ovf <= (t1_div == 2'h3);
    end
    assign rxd_line = pins.rxd_oe ? pins.rxd_o : far_rxd;
    spb_serial u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd_i(rxd_line), .timer2_ext_pin_i(timer2_ext_pin), .t2_pin_i(1'b1), .pins(pins), .t1_overflow(t1_ovf));
    spb_far_end u_far (.clock(clock), .txd(pins.txd_o), .data_in(pins.rxd_o), .data_oe(pins.rxd_oe),
        .rxd(far_rxd));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_flag(input int b);
        k = 0;
        do apb(1'b0, `SPB_OFF_CTRL, 32'h0); while (rd[b] !== 1'b1 && ++k < 2000);
        if (k >= 2000) n_fail++;
    endtask
    task automatic results;
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        apb(1'b0, `SPB_OFF_CTRL, 32'h0);
        check("ctrl reset", rd, `SPB_CTRL_RST);
        apb(1'b0, `SPB_OFF_T2CTRL, 32'h0);
        check("t2ctrl reset", rd, `SPB_T2CTRL_RST);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    endtask
    task automatic t_mode0;
        apb(1'b1, `SPB_OFF_BUF, 32'hA5);
        wait_flag(`SPB_F_TXF);
        check("m0 tx data", u_far.sh_in, 32'hA5);
        check("m0 tx flag time", (k >= 35 && k <= 41), 1);
        u_far.load0(8'h35);
        apb(1'b1, `SPB_OFF_CTRL, 32'h10);
        wait_flag(`SPB_F_RXF);
        apb(1'b0, `SPB_OFF_BUF, 32'h0);
        check("m0 rx data", rd[7:0], 32'h35);
    endtask
    task automatic t_mode1;
        apb(1'b1, `SPB_OFF_CTRL, 32'h40);
        u_far.mode1 = 1'b1;
        // timer stopped while reload and count are loaded
        apb(1'b1, `SPB_OFF_RELOAD, 32'hFFFE);
        apb(1'b1, `SPB_OFF_T2CNT, 32'hFFFE);
        apb(1'b1, `SPB_OFF_T2CTRL, 32'h1D);
        apb(1'b1, `SPB_OFF_BUF, 32'h5A);
        wait_flag(`SPB_F_TXF);
        repeat (80) @(posedge clock);
        check("m1 tx data", u_far.sh_in, 32'h5A);
        check("m1 framing", u_far.frame_ok, 1);
        apb(1'b1, `SPB_OFF_CTRL, 32'h50);
        u_far.send(8'hC1, 1'b1);
        wait_flag(`SPB_F_RXF);
        check("m1 ninth", rd[`SPB_F_R9], 1);
        apb(1'b0, `SPB_OFF_BUF, 32'h0);
        check("m1 rx data", rd[7:0], 32'hC1);
        u_far.send(8'h11, 1'b1);
        apb(1'b0, `SPB_OFF_BUF, 32'h0);
        check("flag set drop", rd[7:0], 32'hC1);
    endtask
    task automatic t_reject;
        apb(1'b1, `SPB_OFF_CTRL, 32'h70);
        u_far.glitch();
        repeat (700) @(posedge clock);
        u_far.send(8'h22, 1'b0);
        apb(1'b0, `SPB_OFF_CTRL, 32'h0);
        check("false start or bad stop", rd[`SPB_F_RXF], 0);
        u_far.send(8'h96, 1'b1);
        wait_flag(`SPB_F_RXF);
        apb(1'b0, `SPB_OFF_BUF, 32'h0);
        check("rehunt data", rd[7:0], 32'h96);
        apb(1'b1, `SPB_OFF_CTRL, 32'h40);
        u_far.send(8'h77, 1'b1);
        apb(1'b0, `SPB_OFF_CTRL, 32'h0);
        check("rx disabled", rd[`SPB_F_RXF], 0);
    endtask
    task automatic t_timer;
        timer2_ext_pin <= 1'b0;
        repeat (8) @(posedge clock);
        apb(1'b0, `SPB_OFF_T2CTRL, 32'h0);
        check("ext flag", rd[`SPB_F_EXF], 1);
        check("no overflow flag", rd[`SPB_F_RCLK], 0);
        // outside baud mode the rollover does set the flag, and software clears it
        apb(1'b1, `SPB_OFF_T2CTRL, 32'h04);
        repeat (8) @(posedge clock);
        apb(1'b0, `SPB_OFF_T2CTRL, 32'h0);
        check("overflow flag", rd[`SPB_F_RCLK], 1);
        // second write: the first may meet a last rollover, and the set wins
        apb(1'b1, `SPB_OFF_T2CTRL, 32'h00);
        apb(1'b1, `SPB_OFF_T2CTRL, 32'h00);
        apb(1'b0, `SPB_OFF_T2CTRL, 32'h0);
        check("overflow clear", rd[`SPB_F_RCLK], 0);
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        results();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_mode0();
        t_mode1();
        t_reject();
        t_timer();
        results();
    end
endmodule
